/* File: sioc_center.sv */
// Purpose: host-side address map and link control of the serial I/O center
// Assumes: async host pins sampled through two flops; one 200 MHz clock
// Notes: host access is a strobe on rd_n/wr_n; reads answer one cycle later
`timescale 1ns/10ps
module sioc_center
  import sioc_pkg::*;
#(
  parameter int NDEV_P = NDEV,
  parameter int FRAME_WORDS_P = FRAME_MAX_WORDS
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [8:0] addr,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic dq_oe,
  input wire logic reduced_mode,
  input wire logic clk_sel,
  input wire logic [1:0] spd_sel,
  input wire logic si,
  output logic so,
  output logic so_oe,
  output logic busy_n,
  output logic scan_toggle
);
  // ==========================================================
  // pin synchronisers
  logic [2:0] ctl_s1_q, ctl_s2_q, ctl_s3_q;
  logic [8:0] a_s1_q, a_s2_q;
  logic [15:0] d_s1_q, d_s2_q;
  logic [1:0] spd_s1_q, spd_s2_q;
  logic mode_s1_q, mode_s2_q, ck_s1_q, ck_s2_q, si_s1_q, si_s2_q;
  always_ff @(posedge clk) begin
    ctl_s1_q <= {cs_n, rd_n, wr_n};
    ctl_s2_q <= ctl_s1_q;
    ctl_s3_q <= ctl_s2_q;
    a_s1_q <= addr;
    a_s2_q <= a_s1_q;
    d_s1_q <= dq_in;
    d_s2_q <= d_s1_q;
    spd_s1_q <= spd_sel;
    spd_s2_q <= spd_s1_q;
    mode_s1_q <= reduced_mode;
    mode_s2_q <= mode_s1_q;
    ck_s1_q <= clk_sel;
    ck_s2_q <= ck_s1_q;
    si_s1_q <= si;
    si_s2_q <= si_s1_q;
  end
  // ==========================================================
  // strobe decode
  logic sel_rd, sel_wr, rd_stb, wr_stb;
  assign sel_rd = !ctl_s2_q[2] && !ctl_s2_q[1];
  assign sel_wr = !ctl_s2_q[2] && !ctl_s2_q[0];
  assign rd_stb = sel_rd && (ctl_s3_q[2] || ctl_s3_q[1]);
  // write taken on the trailing edge so data has settled
  assign wr_stb = !sel_wr && !ctl_s3_q[2] && !ctl_s3_q[0];
  logic [8:0] wr_addr_q;
  logic [15:0] wr_data_q;
  always_ff @(posedge clk) begin
    if (sel_wr) begin
      wr_addr_q <= a_s2_q;
      wr_data_q <= d_s2_q;
    end
  end
  // ==========================================================
  // address translation: direct or indirect through the buffer
  logic bufmode_q;
  logic [8:0] iaddr_q;
  logic [8:0] ra, wa;
  logic r_idx, w_idx;
  function automatic logic [8:0] eff_addr(input logic red, input logic bm,
                                          input logic [8:0] a, input logic [8:0] ia);
    // reduced mode looks only at three address lines
    if (red && bm && a[2:0] == WIN_IDATA) begin
      eff_addr = ia; // RULE_07
    end else if (red) begin
      eff_addr = {6'h00, a[2:0]}; // RULE_06
    end else begin
      eff_addr = a; // RULE_05
    end
  endfunction
  assign ra = eff_addr(mode_s2_q, bufmode_q, a_s2_q, iaddr_q);
  assign wa = eff_addr(mode_s2_q, bufmode_q, wr_addr_q, iaddr_q);
  assign r_idx = mode_s2_q && a_s2_q[2:0] == WIN_IADDR;
  assign w_idx = mode_s2_q && wr_addr_q[2:0] == WIN_IADDR;
  // ==========================================================
  // area decode
  function automatic logic [2:0] area(input logic [8:0] a);
    if (a[8]) area = 3'd5;
    else if (a >= OFS_CHFL_LO) area = 3'd4;
    else if (a >= OFS_CHEN_LO) area = 3'd3;
    else if (a >= OFS_CERR_LO) area = 3'd2;
    else if (a >= OFS_INFO_LO) area = 3'd1;
    else area = 3'd0;
  endfunction
  logic [2:0] r_area, w_area;
  assign r_area = area(ra);
  assign w_area = area(wa);
  logic w_info, w_cerr, w_chen, w_chfl, w_port, w_cmd, w_fifo;
  assign w_info = wr_stb && !w_idx && w_area == 3'd1; // RULE_08
  assign w_cerr = wr_stb && !w_idx && w_area == 3'd2; // RULE_09
  assign w_chen = wr_stb && !w_idx && w_area == 3'd3; // RULE_10
  assign w_chfl = wr_stb && !w_idx && w_area == 3'd4; // RULE_11
  assign w_port = wr_stb && !w_idx && w_area == 3'd5; // RULE_12
  assign w_cmd = wr_stb && !w_idx && wa[8:1] == OFS_CMD_STAT[8:1]; // RULE_17
  assign w_fifo = wr_stb && !w_idx && wa[8:1] == OFS_FIFO[8:1]; // RULE_17
  // ==========================================================
  // storage
  logic [7:0] info_mem [NDEV];
  logic [7:0] chen_mem [32];
  logic [7:0] port_mem [IO_BYTES];
  logic [15:0] txbuf [DATA_BYTES/4];
  logic [15:0] rxbuf [DATA_BYTES/4];
  logic [63:0] cerr_q;
  logic [255:0] chfl_q;
  logic [6:0] tx_wp_q, rx_rp_q;
  logic [7:0] tx_n_q, rx_n_q;
  logic [5:0] ndev_q;
  logic scan_q, done_q;
  logic [7:0] cmd_code;
  // last word of a data frame leaves the buffer; read by the link engine too
  logic sent_frame;
  assign cmd_code = wr_data_q[7:0];
  always_ff @(posedge clk) begin
    if (w_info) info_mem[wa[5:0] - 6'h38] <= wr_data_q[7:0]; // RULE_08
    if (w_chen) chen_mem[wa[4:0]] <= wr_data_q[7:0]; // RULE_10
    if (w_fifo && tx_n_q < 8'(FRAME_WORDS_P)) txbuf[tx_wp_q] <= wr_data_q; // RULE_14
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bufmode_q <= 1'b0;
      iaddr_q <= 9'h000;
      scan_q <= 1'b0;
      ndev_q <= 6'h07;
      tx_wp_q <= 7'h00;
      tx_n_q <= 8'h00;
    end else begin
      if (wr_stb && w_idx) iaddr_q <= wr_data_q[8:0];
      if (w_fifo && tx_n_q < 8'(FRAME_WORDS_P)) begin
        tx_wp_q <= tx_wp_q + 7'h01;
        tx_n_q <= tx_n_q + 8'h01;
      end
      if (w_cmd) begin
        case (cmd_code)
          CMD_SCAN_START: scan_q <= 1'b1;
          CMD_SCAN_STOP: scan_q <= 1'b0;
          CMD_BUF_ACCESS: bufmode_q <= wr_data_q[8]; // RULE_07
          CMD_SET_NDEV: ndev_q <= wr_data_q[13:8]; // RULE_15
          default: ;
        endcase
      end
      if (sent_frame) begin
        tx_wp_q <= 7'h00;
        tx_n_q <= 8'h00;
      end
    end
  end
  // ==========================================================
  // link engine
  typedef enum logic [2:0] {LK_IDLE, LK_POLL, LK_WAIT, LK_FRAME, LK_GAP} sioc_lk_t;
  sioc_lk_t lk_q;
  logic bit_en, tx_go, tx_busy, rx_valid;
  logic [15:0] tx_word, rx_word;
  logic [5:0] dev_q;
  logic [7:0] fidx_q;
  logic [9:0] tmo_q;
  logic frame_req_q;
  sioc_bitclk u_bitclk (
    .clk(clk), .nrst(nrst), .spd(spd_s2_q), .bit_en(bit_en) // RULE_02
  );
  sioc_serdes u_serdes (
    .clk(clk), .nrst(nrst), .bit_en(bit_en), .tx_go(tx_go), .tx_word(tx_word),
    .tx_busy(tx_busy), .so(so), .so_oe(so_oe), .rx_in(si_s2_q),
    .rx_valid(rx_valid), .rx_word(rx_word)
  );
  // the bit rate comes from clk; the reference pin is synchronised but drives nothing
  logic ck80_unused;
  assign ck80_unused = ck_s2_q; // RULE_01
  assign tx_go = (lk_q == LK_POLL || lk_q == LK_FRAME) && !tx_busy;
  // poll word: device number and its first port byte
  assign tx_word = (lk_q == LK_FRAME) ? txbuf[fidx_q[6:0]]
                 : {2'b00, dev_q, port_mem[{dev_q, 2'b00}]};
  assign sent_frame = lk_q == LK_FRAME && tx_go && fidx_q + 8'h01 >= tx_n_q;
  logic poll_ok, poll_err;
  assign poll_ok = lk_q == LK_WAIT && rx_valid;
  assign poll_err = lk_q == LK_WAIT && tmo_q == 10'h3ff;
  // ==========================================================
  // slot pacing
  // every device owns one fixed slot, so without data frames the scan period depends only on
  // the device count and the line rate, not on how fast a device answers
  logic [15:0] slot_q;
  logic [15:0] slot_len;
  logic slot_end;
  assign slot_len = 16'(SLOT_CYC_20M << (2'd3 - spd_s2_q)); // RULE_03
  // a rate change mid-slot only shortens or stretches the slot in progress
  assign slot_end = slot_q >= slot_len - 16'h0001;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lk_q <= LK_IDLE;
      dev_q <= 6'h00;
      fidx_q <= 8'h00;
      tmo_q <= 10'h000;
      frame_req_q <= 1'b0;
      scan_toggle <= 1'b0;
      done_q <= 1'b0;
      slot_q <= 16'h0000;
    end else begin
      // slot timer runs from the start of a poll or frame until idle again
      slot_q <= (lk_q == LK_IDLE) ? 16'h0000 : slot_q + 16'h0001; // RULE_03
      if (w_cmd && cmd_code == CMD_SEND_FRAME && tx_n_q != 8'h00) frame_req_q <= 1'b1; // RULE_14
      if (w_cmd && cmd_code == CMD_SEND_FRAME) done_q <= 1'b0;
      case (lk_q)
        LK_IDLE: begin
          if (frame_req_q) begin
            lk_q <= LK_FRAME; // RULE_12
            fidx_q <= 8'h00;
          end else if (scan_q) begin
            lk_q <= LK_POLL;
          end
        end
        LK_POLL: if (tx_go) lk_q <= LK_WAIT;
        LK_WAIT: begin
          tmo_q <= tmo_q + 10'h001;
          if (poll_ok || poll_err) begin
            tmo_q <= 10'h000;
            lk_q <= LK_GAP;
          end
        end
        LK_FRAME: begin
          if (tx_go) fidx_q <= fidx_q + 8'h01;
          if (sent_frame) begin
            frame_req_q <= 1'b0;
            done_q <= 1'b1;
            lk_q <= LK_GAP;
          end
        end
        LK_GAP: begin
          if (!tx_busy && slot_end) begin
            lk_q <= LK_IDLE;
            // a data frame and every poll after it leave the device sequence alone until done_q clears, except the wrap at ndev_q
            if (dev_q == ndev_q) begin // RULE_04
              dev_q <= 6'h00;
              scan_toggle <= !scan_toggle; // RULE_03
            end else if (!done_q || fidx_q == 8'h00) begin
              dev_q <= dev_q + 6'h01;
            end
          end
        end
        default: lk_q <= LK_IDLE;
      endcase
    end
  end
  // ==========================================================
  // flags and FIFO: hardware set beats host clear or pop; a host port write beats a received port byte
  logic [255:0] chg_set;
  logic [7:0] old_in;
  logic [7:0] in_idx;
  assign in_idx = {dev_q, 2'b01};
  assign old_in = port_mem[in_idx];
  genvar gi;
  generate
    for (gi = 0; gi < 256; gi++) begin : g_chg
      assign chg_set[gi] = poll_ok && in_idx == 8'(gi >> 3)
        && ((old_in[gi % 8] ^ rx_word[gi % 8]) && chen_mem[gi >> 3][gi % 8]);
    end
  endgenerate
  logic [63:0] cerr_set;
  assign cerr_set = poll_err ? (64'h1 << dev_q) : 64'h0;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cerr_q <= 64'h0;
      chfl_q <= 256'h0;
      rx_n_q <= 8'h00;
      rx_rp_q <= 7'h00;
    end else begin
      cerr_q <= (cerr_q & ~(w_cerr ? (64'hff << {wa[2:0], 3'b000}) : 64'h0))
                | cerr_set; // RULE_09
      chfl_q <= (chfl_q & ~(w_chfl ? (256'hff << {wa[4:0], 3'b000}) : 256'h0))
                | chg_set; // RULE_11
      if (rx_valid && lk_q == LK_IDLE && rx_n_q < 8'(FRAME_WORDS_P)) begin
        rx_n_q <= rx_n_q + 8'h01;
      end else if (rd_stb && ra[8:1] == OFS_FIFO[8:1] && rx_n_q != 8'h00) begin
        rx_n_q <= rx_n_q - 8'h01;
        rx_rp_q <= rx_rp_q + 7'h01;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (w_port) port_mem[wa[7:0]] <= wr_data_q[7:0]; // RULE_12
    else if (poll_ok) port_mem[in_idx] <= rx_word[7:0]; // RULE_12
    if (rx_valid && lk_q == LK_IDLE) rxbuf[7'(rx_rp_q + rx_n_q[6:0])] <= rx_word;
  end
  // ==========================================================
  // read mux
  logic [15:0] stat, rdata;
  assign stat = {10'h000, done_q, frame_req_q, bufmode_q, rx_n_q != 8'h00, tx_busy, scan_q};
  always_comb begin
    rdata = 16'h0000;
    if (r_idx) rdata = {7'h00, iaddr_q};
    else if (ra[8:1] == OFS_CMD_STAT[8:1]) rdata = stat; // RULE_17
    else if (ra[8:1] == OFS_IRQ_STAT[8:1]) rdata = {14'h0, chfl_q != 256'h0, cerr_q != 64'h0};
    else if (ra[8:1] == OFS_FIFO[8:1]) rdata = rxbuf[rx_rp_q];
    else begin
      case (r_area)
        3'd1: rdata = {8'h00, info_mem[ra[5:0] - 6'h38]}; // RULE_08
        3'd2: rdata = {8'h00, cerr_q[{ra[2:0], 3'b000} +: 8]}; // RULE_09
        3'd3: rdata = {8'h00, chen_mem[ra[4:0]]}; // RULE_10
        3'd4: rdata = {8'h00, chfl_q[{ra[4:0], 3'b000} +: 8]}; // RULE_11
        3'd5: rdata = {8'h00, port_mem[ra[7:0]]}; // RULE_12
        default: rdata = 16'h0000; // RULE_13
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dq_out <= 16'h0000;
    end else if (rd_stb) begin
      dq_out <= rdata;
    end
  end
  assign dq_oe = sel_rd;
  assign busy_n = !(frame_req_q || lk_q == LK_FRAME);
endmodule

/* File: sioc_pkg.sv */
// Purpose: constants for the serial I/O center host map and link timing
// Assumes: 200 MHz core clock, byte-wide host map, 16-bit words at 000h..005h
// Notes: the list below summarises the block's behaviour
// Overview of operation
// RULE_01 - reference clock pin picks 40 or 80 MHz; top line rate 20 Mbps either way
// RULE_02 - speed pins pick 2.5, 5, 10 or 20 Mbps; reference clock unchanged
// RULE_03 - full scan of 8 devices about 0.12 ms, 64 devices about 0.97 ms
// RULE_04 - data-type devices take I/O points; only data traffic stretches scans
// RULE_05 - normal host mode decodes nine address lines, 512 bytes
// RULE_06 - reduced host mode uses three address lines, an 8-byte window
// RULE_07 - an operation command opens the whole map through one buffer, slower
// RULE_08 - 078h..0B7h hold one read/write info byte per device, 64 devices
// RULE_09 - 0B8h..0BFh read cyclic error flags; writes clear them
// RULE_10 - 0C0h..0DFh hold read/write input change interrupt enables
// RULE_11 - 0E0h..0FFh read latched change flags; writes clear them
// RULE_12 - 100h..1FFh hold cyclic port data; data devices use transient frames
// RULE_13 - host treats 008h..077h as undefined
// RULE_14 - a transient frame carries 1 to 128 words of 16 bits
// RULE_15 - 256 bytes I/O buffer, 512 bytes data buffer, devices 0 to 63
// RULE_16 - NRZ half-duplex line; never sends and receives at once
// RULE_17 - 000h command/status, 002h interrupt status, 004h data FIFO, 16-bit
package sioc_pkg;
  // ==========================================================
  // address map
  localparam logic [8:0] OFS_CMD_STAT = 9'h000;
  localparam logic [8:0] OFS_IRQ_STAT = 9'h002;
  localparam logic [8:0] OFS_FIFO = 9'h004;
  localparam logic [8:0] OFS_INFO_LO = 9'h078;
  localparam logic [8:0] OFS_INFO_HI = 9'h0b7;
  localparam logic [8:0] OFS_CERR_LO = 9'h0b8;
  localparam logic [8:0] OFS_CERR_HI = 9'h0bf;
  localparam logic [8:0] OFS_CHEN_LO = 9'h0c0;
  localparam logic [8:0] OFS_CHEN_HI = 9'h0df;
  localparam logic [8:0] OFS_CHFL_LO = 9'h0e0;
  localparam logic [8:0] OFS_CHFL_HI = 9'h0ff;
  localparam logic [8:0] OFS_PORT_LO = 9'h100;
  // reduced-mode window: 0/1 cmd, 2/3 irq, 4/5 fifo, 6 indirect addr, 7 indirect data
  localparam logic [2:0] WIN_IADDR = 3'h6;
  localparam logic [2:0] WIN_IDATA = 3'h7;
  // ==========================================================
  // commands (low byte of a command word)
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_SCAN_START = 8'h01;
  localparam logic [7:0] CMD_SCAN_STOP = 8'h02;
  localparam logic [7:0] CMD_BUF_ACCESS = 8'h03;
  localparam logic [7:0] CMD_SEND_FRAME = 8'h04;
  localparam logic [7:0] CMD_SET_NDEV = 8'h05;
  // status bit positions
  localparam int ST_SCAN = 0;
  localparam int ST_TX = 1;
  localparam int ST_RX = 2;
  localparam int ST_BUFMODE = 3;
  localparam int ST_BUSY = 4;
  localparam int ST_DONE = 5;
  // ==========================================================
  // sizes
  localparam int NDEV = 64;
  localparam int IO_BYTES = 256;
  localparam int DATA_BYTES = 512;
  localparam int FRAME_MAX_WORDS = 128;
  localparam int WORD_W = 16;
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 200;
  localparam int LINE_MAX_MBPS = 20;
  localparam int BIT_DIV_20M = CLK_MHZ / LINE_MAX_MBPS;
  localparam int IDX_WAIT_CYC = 2;
  localparam int SCAN8_US_X100 = 12;
  localparam int SCAN64_US_X100 = 97;
  // one device slot at 20 Mbps: 8 slots about 0.12 ms, 64 slots about 0.97 ms
  localparam int SLOT_CYC_20M = 3000;
  typedef enum logic [1:0] {SPD_2M5, SPD_5M, SPD_10M, SPD_20M} sioc_spd_t;
endpackage

/* File: sioc_bitclk.sv */
// Purpose: line bit-rate enable pulse generator
// Assumes: clk 200 MHz, speed pins already synchronised
// Notes: rate is independent of the reference clock pin
`timescale 1ns/10ps
module sioc_bitclk
  import sioc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] spd,
  output logic bit_en
);
  logic [7:0] cnt_q;
  logic [7:0] lim;
  // ==========================================================
  // divider: 20 Mbps base, halved per step down
  assign lim = 8'(BIT_DIV_20M << (2'd3 - spd)) - 8'h01; // RULE_02
  assign bit_en = (cnt_q == lim);
  always_ff @(posedge clk) begin
    if (!nrst || bit_en) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

/* File: sioc_serdes.sv */
// Purpose: half-duplex NRZ shifter for 16-bit words
// Assumes: bit_en pulses once per line bit; rx already synchronised
// Notes: start bit low, 16 data bits lsb first, stop bit high
`timescale 1ns/10ps
module sioc_serdes
  import sioc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic bit_en,
  input wire logic tx_go,
  input wire logic [15:0] tx_word,
  output logic tx_busy,
  output logic so,
  output logic so_oe,
  input wire logic rx_in,
  output logic rx_valid,
  output logic [15:0] rx_word
);
  logic [17:0] tsh_q;
  logic [4:0] tcnt_q;
  logic [16:0] rsh_q;
  logic [4:0] rcnt_q;
  logic rx_arm;
  assign tx_busy = (tcnt_q != 5'd0);
  // receive only while not transmitting
  assign rx_arm = !tx_busy && !tx_go; // RULE_16
  // ==========================================================
  // transmitter
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tsh_q <= 18'h3ffff;
      tcnt_q <= 5'd0;
      so <= 1'b1;
      so_oe <= 1'b0;
    end else if (tx_go && !tx_busy) begin
      tsh_q <= {1'b1, tx_word, 1'b0};
      tcnt_q <= 5'd18;
      so_oe <= 1'b1; // RULE_16
    end else if (bit_en && tx_busy) begin
      so <= tsh_q[0];
      tsh_q <= {1'b1, tsh_q[17:1]};
      tcnt_q <= tcnt_q - 5'd1;
    end else if (!tx_busy) begin
      so_oe <= 1'b0;
    end
  end
  // ==========================================================
  // receiver
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rsh_q <= 17'h0;
      rcnt_q <= 5'd0;
      rx_valid <= 1'b0;
      rx_word <= 16'h0;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_arm) begin
        rcnt_q <= 5'd0;
      end else if (bit_en) begin
        if (rcnt_q == 5'd0) begin
          if (!rx_in) begin
            rcnt_q <= 5'd17;
          end
        end else begin
          rsh_q <= {rx_in, rsh_q[16:1]};
          rcnt_q <= rcnt_q - 5'd1;
          if (rcnt_q == 5'd1 && rx_in) begin
            rx_valid <= 1'b1;
            rx_word <= rsh_q[16:1];
          end
        end
      end
    end
  end
endmodule

/* File: sioc_monitor.sv */
// Purpose: port checker for sioc_center
// Assumes: one 200 MHz clock, nrst synchronous active low
// Notes: bound from the testbench top file
`timescale 1ns/10ps
module sioc_monitor
  import sioc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [8:0] addr,
  input wire logic [15:0] dq_in,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe,
  input wire logic reduced_mode,
  input wire logic clk_sel,
  input wire logic [1:0] spd_sel,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic busy_n,
  input wire logic scan_toggle
);
  // ==========================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire rd_sel = !cs_n && !rd_n;
  sequence s_hole_rd;
    $fell(rd_n) && !cs_n && !reduced_mode && addr >= 9'h008 && addr <= 9'h077;
  endsequence
  sequence s_zero_answer;
    ##5 dq_out == 16'h0000;
  endsequence
  AST_RST_VAL: assert property ($rose(nrst) |-> dq_out == 16'h0000 && so && !so_oe)
    else $error("outputs not at reset values");
  AST_HOLE_RD: assert property (s_hole_rd |-> s_zero_answer)
    else $error("undefined area read not zero");
  AST_OE_SRC: assert property (dq_oe |-> $past(rd_sel, 2) || $past(rd_sel, 3))
    else $error("data bus driven without a read");
  AST_OE_IDLE: assert property (cs_n [*4] |-> !dq_oe)
    else $error("data bus driven while deselected");
  AST_HOLD: assert property (!dq_oe [*3] |-> $stable(dq_out))
    else $error("read data changed outside a read");
  AST_TOGGLE: assert property ($changed(scan_toggle) |=> $stable(scan_toggle) [*8])
    else $error("scan toggle flips too fast");
  AST_BIT: assert property (so_oe && $past(so_oe) && $changed(so) |=> $stable(so) [*8])
    else $error("serial bit shorter than line bit time");
  AST_FRAME: assert property ($rose(so_oe) |-> so_oe [*8])
    else $error("serial output enable pulse too short");
endmodule

/* File: sioc_partner.sv */
// Purpose: behavioural local device on the serial line
// Assumes: line idles high, word is start 0, 16 bits lsb first, stop 1
// Notes: replies only after the center releases the line
`timescale 1ns/10ps
module sioc_partner
  import sioc_pkg::*;
(
  input wire logic clk,
  input wire logic so,
  input wire logic so_oe,
  input wire logic [1:0] spd,
  input wire logic [7:0] lat,
  input wire logic clr,
  output logic si,
  output logic clash,
  output int min_run
);
  // ==========================================================
  // line watch and reply
  int run = 1000;
  int bit_cyc;
  logic so_last = 1'b1;
  logic [15:0] reply = 16'h0000;
  initial si = 1'b1;
  initial clash = 1'b0;
  initial min_run = 1000;
  assign bit_cyc = BIT_DIV_20M << (3 - spd);
  always @(posedge clk) begin
    so_last <= so;
    run <= !so_oe ? 1000 : (so != so_last) ? 1 : run + 1;
    if (so_oe && so != so_last && run < min_run) min_run <= run;
    if (so_oe && !si) clash <= 1'b1;
    if (clr) begin
      min_run <= 1000;
      clash <= 1'b0;
    end
  end
  always begin
    @(negedge so_oe);
    repeat (lat) @(posedge clk);
    if (!so_oe) begin
      reply = reply + 16'h0001;
      for (int b = 0; b < 18; b++) begin
        @(posedge clk);
        si <= (b == 0) ? 1'b0 : (b == 17) ? 1'b1 : reply[b - 1];
        repeat (bit_cyc - 1) @(posedge clk);
      end
    end
  end
endmodule

/* File: sioc_center_test.sv */
// Purpose: self-checking bench for sioc_center
// Assumes: 200 MHz clock, inputs driven on the falling edge
// Notes: byte map modelled in an array, scan timed by scan_toggle
`timescale 1ns/10ps
module sioc_center_test
  import sioc_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic [8:0] addr = 9'h000;
  logic [15:0] dq_in = 16'h0000;
  logic reduced_mode = 1'b0;
  logic clk_sel = 1'b0;
  logic [1:0] spd_sel = 2'h3;
  logic [7:0] lat = 8'h10;
  logic clr = 1'b0;
  logic [15:0] dq_out;
  logic dq_oe, si, so, so_oe, busy_n, scan_toggle, clash;
  int min_run, i, t0, t1, seed_v;
  int cyc = 0;
  int miscompares = 0;
  int n_tests = 0;
  logic [7:0] mdl [0:511];
  logic [7:0] v;
  logic [15:0] d;
  always #2.5 clk = ~clk;
  sioc_center u_dut (.clk(clk), .nrst(nrst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .reduced_mode(reduced_mode), .clk_sel(clk_sel), .spd_sel(spd_sel), .si(si),
    .so(so), .so_oe(so_oe), .busy_n(busy_n), .scan_toggle(scan_toggle));
  sioc_partner u_far (.clk(clk), .so(so), .so_oe(so_oe), .spd(spd_sel), .lat(lat),
    .clr(clr), .si(si), .clash(clash), .min_run(min_run));
  // ==========================================================
  // tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] w);
    @(negedge clk);
    cs_n = 1'b0;
    wr_n = 1'b0;
    addr = a;
    dq_in = w;
    repeat (6) @(negedge clk);
    cs_n = 1'b1;
    wr_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  task automatic rd(input logic [8:0] a, output logic [15:0] r);
    @(negedge clk);
    cs_n = 1'b0;
    rd_n = 1'b0;
    addr = a;
    repeat (7) @(negedge clk);
    r = dq_out;
    cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  task automatic wait_tog(output int t);
    logic s;
    int k;
    s = scan_toggle;
    for (k = 0; k < 40000 && scan_toggle === s; k++) @(negedge clk);
    t = cyc;
  endtask
  task automatic final_report();
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      miscompares++;
      final_report();
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    seed_v = $urandom(15352);
    repeat (12) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    chk({so_oe, so, busy_n, scan_toggle}, 16'h0006);
    // byte map: hole reads zero, flag areas clear on write, the rest holds data
    for (i = 8; i < 512; i++) begin
      v = 8'($urandom);
      wr(9'(i), {8'h00, v});
      mdl[i] = (i < 'h78 || (i >= 'hb8 && i < 'hc0) || (i >= 'he0 && i < 'h100)) ? 8'h00 : v;
    end
    for (i = 8; i < 512; i++) begin
      rd(9'(i), d);
      chk({8'h00, d[7:0]}, {8'h00, mdl[i]});
    end
    // reduced window, upper address bits carry junk
    reduced_mode = 1'b1;
    wr({6'h2a, 3'h0}, 16'h0103);
    rd({6'h15, 3'h0}, d);
    chk(d & (16'h0001 << ST_BUFMODE), 16'h0001 << ST_BUFMODE);
    wr({6'h3f, WIN_IADDR}, 16'h00c5);
    rd({6'h01, WIN_IDATA}, d);
    chk({8'h00, d[7:0]}, {8'h00, mdl['hc5]});
    v = 8'($urandom);
    wr({6'h11, WIN_IDATA}, {8'h00, v});
    wr({6'h05, 3'h0}, 16'h0003);
    reduced_mode = 1'b0;
    rd(9'h0c5, d);
    chk({8'h00, d[7:0]}, {8'h00, v});
    // scan at 10 Mbps, slow partner
    spd_sel = 2'h2;
    lat = 8'(20 + $urandom % 40);
    wr(9'h000, {8'h00, CMD_SCAN_START});
    rd(9'h000, d);
    chk(d & 16'h0001, 16'h0001);
    repeat (3000) @(negedge clk);
    chk(16'(min_run), 16'd20);
    wr(9'h000, {8'h00, CMD_SCAN_STOP});
    repeat (2000) @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    // scan at 20 Mbps with the other reference clock, prompt partner
    spd_sel = 2'h3;
    clk_sel = 1'b1;
    lat = 8'(2 + $urandom % 4);
    wr(9'h000, {8'h00, CMD_SCAN_START});
    wait_tog(t0);
    wait_tog(t1);
    chk(16'(t1 - t0 >= 20000 && t1 - t0 <= 28000), 16'h0001);
    chk(16'(min_run), 16'd10);
    chk(16'(clash), 16'h0000);
    final_report();
  end
endmodule
bind sioc_center sioc_monitor u_mon (.clk(clk), .nrst(nrst), .cs_n(cs_n), .rd_n(rd_n),
  .wr_n(wr_n), .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
  .reduced_mode(reduced_mode), .clk_sel(clk_sel), .spd_sel(spd_sel), .si(si),
  .so(so), .so_oe(so_oe), .busy_n(busy_n), .scan_toggle(scan_toggle));
